// >>> core/cbi_pkg.sv
// Constants, field layout and phase type of the buffer interrupt controller.
// Assumes one clock domain and an APB master with 32-bit data.
//
// Summary of operation
// - Enable bit 31 gates every interrupt
// - Reserved bits read zero, ignore writes
// - Four per-source enables, reset to disabled
// - Owner field change sets status bit 3
// - Grant from no owner sets nothing
// - Completed flag clear sets status bit 2
// - Ready entry after request sets bit 1
// - Finished launched command sets bit 0
// - Cancelled command also sets bit 0
// - Status bits clear only on write one
package cbi_pkg;

    // ----------------------------------------------------------------
    // Bus geometry and register map
    // ----------------------------------------------------------------
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned ADDR_W     = 12;
    localparam logic [11:0] OFS_ENABLE = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [31:0] RD_ZERO    = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int unsigned BIT_GATE   = 31;
    localparam int unsigned SRC_N      = 4;
    localparam int unsigned SRC_OWNER  = 3;
    localparam int unsigned SRC_FLAG   = 2;
    localparam int unsigned SRC_READY  = 1;
    localparam int unsigned SRC_CMD    = 0;
    localparam logic [3:0]  SRC_RST    = 4'h0;
    localparam logic        GATE_RST   = 1'b0;

    // ----------------------------------------------------------------
    // Side inputs
    // ----------------------------------------------------------------
    localparam int unsigned OWNER_W      = 3;
    localparam int unsigned START_W      = 4;
    localparam logic [3:0]  START_LAUNCH = 4'h1;
    localparam logic [3:0]  START_CLEAR  = 4'h0;

    // ----------------------------------------------------------------
    // APB phase tracker
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_IDLE   = 2'b01,
        PH_ACCESS = 2'b10
    } cbi_phase_type;

endpackage : cbi_pkg

// >>> core/cbi_change_det.sv
// Change detector: remembers the last value of a level and flags a change.
// Assumes the watched level is synchronous to the clock.
module cbi_change_det #(
    parameter int unsigned WIDTH = 3
) (
    input  wire logic             mclk_in,
    input  wire logic             sys_rst_in,
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] prev_out,
    output logic                  changed_out
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] prev_q, prev_d;
    logic             valid_q, valid_d;

    initial begin
        if (WIDTH < 1) begin
            $error("cbi_change_det: WIDTH must be at least 1");
        end
    end

    // Valid flag hides the reset value, so a nonzero level is no false change
    always_comb begin
        prev_d  = level_in;
        valid_d = 1'b1;
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            prev_q  <= '0;
            valid_q <= 1'b0;
        end else begin
            prev_q  <= prev_d;
            valid_q <= valid_d;
        end
    end

    assign prev_out    = prev_q;
    assign changed_out = valid_q && (level_in != prev_q);

endmodule : cbi_change_det

// >>> core/cbi_irq_ctrl.sv
// Interrupt enable and sticky status logic of the command response buffer.
// Assumes an APB master on mclk_in and event levels synchronous to it.
module cbi_irq_ctrl (
    input  wire logic                          mclk_in,
    input  wire logic                          sys_rst_in,
    // APB slave
    input  wire logic                          apb_psel_in,
    input  wire logic                          apb_penable_in,
    input  wire logic                          apb_pwrite_in,
    input  wire logic [cbi_pkg::ADDR_W-1:0]    apb_paddr_in,
    input  wire logic [cbi_pkg::DATA_W-1:0]    apb_pwdata_in,
    output logic      [cbi_pkg::DATA_W-1:0]    apb_prdata_out,
    output logic                               apb_pready_out,
    output logic                               apb_pslverr_out,
    // Owner state
    input  wire logic [cbi_pkg::OWNER_W-1:0]   owner_field_in,
    input  wire logic                          owner_present_in,
    // Established flag clearing
    input  wire logic                          established_flag_clear_req_in,
    input  wire logic                          established_flag_in,
    // Ready entry
    input  wire logic                          ready_request_in,
    input  wire logic                          idle_flag_in,
    // Command engine
    input  wire logic [cbi_pkg::START_W-1:0]   cmd_launch_ctrl_in,
    input  wire logic                          resp_avail_in,
    input  wire logic                          cmd_cancel_done_in,
    // Interrupt
    output logic                               irq_out
);
    import cbi_pkg::*;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [11:0] ofs);
        addr_is = (addr == ofs);
    endfunction : addr_is

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    cbi_phase_type           phase_q, phase_d;
    logic [DATA_W-1:0]       prdata_q, prdata_d;
    logic                    pslverr_q, pslverr_d;
    logic                    gate_q, gate_d;
    logic [SRC_N-1:0]        en_q, en_d;
    logic [SRC_N-1:0]        status_q, status_d;
    logic                    owner_present_q, owner_present_d;
    logic                    flag_arm_q, flag_arm_d;
    logic                    ready_arm_q, ready_arm_d;
    logic                    cmd_arm_q, cmd_arm_d;
    logic [SRC_N-1:0]        set_vec;
    logic [SRC_N-1:0]        clr_vec;
    logic                    owner_changed;
    logic                    setup_cyc;
    logic                    wr_take;
    logic                    wr_enable;
    logic                    wr_status;

    // ----------------------------------------------------------------
    // APB phase tracking
    // ----------------------------------------------------------------
    // Zero wait states: every access phase completes on its first edge
    assign apb_pready_out  = 1'b1;
    assign apb_prdata_out  = prdata_q;
    assign apb_pslverr_out = pslverr_q;
    assign setup_cyc       = apb_psel_in && !apb_penable_in;
    assign wr_take         = (phase_q == PH_ACCESS) && apb_psel_in && apb_penable_in && apb_pwrite_in;
    assign wr_enable       = wr_take && addr_is(apb_paddr_in, OFS_ENABLE);
    assign wr_status       = wr_take && addr_is(apb_paddr_in, OFS_STATUS);

    // Read data latched in setup so it is a flop output during access
    always_comb begin
        phase_d   = phase_q;
        prdata_d  = prdata_q;
        pslverr_d = pslverr_q;
        case (phase_q)
            PH_IDLE: begin
                if (setup_cyc) begin
                    phase_d = PH_ACCESS;
                end
            end
            PH_ACCESS: begin
                if (!(apb_psel_in && apb_penable_in)) begin
                    phase_d = setup_cyc ? PH_ACCESS : PH_IDLE;
                end else begin
                    phase_d = PH_IDLE;
                end
            end
            default: begin
                phase_d = PH_IDLE;
            end
        endcase
        if (setup_cyc) begin
            prdata_d  = RD_ZERO;
            pslverr_d = 1'b0;
            if (addr_is(apb_paddr_in, OFS_ENABLE)) begin
                prdata_d[BIT_GATE]  = gate_q;
                prdata_d[SRC_N-1:0] = en_q;          // Bits 30:4 stay zero
            end else if (addr_is(apb_paddr_in, OFS_STATUS)) begin
                prdata_d[SRC_N-1:0] = status_q;      // Bits 31:4 stay zero
            end else begin
                pslverr_d = 1'b1;                    // Unmapped address
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            phase_q   <= PH_IDLE;
            prdata_q  <= RD_ZERO;
            pslverr_q <= 1'b0;
        end else begin
            phase_q   <= phase_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ----------------------------------------------------------------
    // Enable register
    // ----------------------------------------------------------------
    // Only the gate and the four source bits are stored; the rest is wired zero
    always_comb begin
        gate_d = gate_q;
        en_d   = en_q;
        if (wr_enable) begin
            gate_d = apb_pwdata_in[BIT_GATE];
            en_d   = apb_pwdata_in[SRC_N-1:0];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            gate_q <= GATE_RST;
            en_q   <= SRC_RST;
        end else begin
            gate_q <= gate_d;
            en_q   <= en_d;
        end
    end

    // ----------------------------------------------------------------
    // Event detection
    // ----------------------------------------------------------------
    cbi_change_det #(
        .WIDTH       (OWNER_W)
    ) u_owner_det (
        .mclk_in     (mclk_in),
        .sys_rst_in  (sys_rst_in),
        .level_in    (owner_field_in),
        .prev_out    (),
        .changed_out (owner_changed)
    );

    // Arms remember a pending request until its completion is seen
    always_comb begin
        owner_present_d = owner_present_in;
        flag_arm_d      = flag_arm_q;
        ready_arm_d     = ready_arm_q;
        cmd_arm_d       = cmd_arm_q;
        set_vec         = '0;
        // Grant from an empty owner slot is immediate and silent
        set_vec[SRC_OWNER] = owner_changed && owner_present_q;
        if (flag_arm_q && !established_flag_in) begin
            set_vec[SRC_FLAG] = 1'b1;
            flag_arm_d        = 1'b0;
        end
        if (established_flag_clear_req_in) begin
            flag_arm_d = 1'b1;
        end
        if (ready_arm_q && !idle_flag_in) begin
            set_vec[SRC_READY] = 1'b1;
            ready_arm_d        = 1'b0;
        end
        if (ready_request_in) begin
            ready_arm_d = 1'b1;
        end
        if (cmd_arm_q && (cmd_launch_ctrl_in == START_CLEAR) && resp_avail_in) begin
            set_vec[SRC_CMD] = 1'b1;
            cmd_arm_d        = 1'b0;
        end
        if (cmd_cancel_done_in) begin
            set_vec[SRC_CMD] = 1'b1;
            cmd_arm_d        = 1'b0;
        end
        if (cmd_launch_ctrl_in == START_LAUNCH) begin
            cmd_arm_d = 1'b1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            owner_present_q <= 1'b0;
            flag_arm_q      <= 1'b0;
            ready_arm_q     <= 1'b0;
            cmd_arm_q       <= 1'b0;
        end else begin
            owner_present_q <= owner_present_d;
            flag_arm_q      <= flag_arm_d;
            ready_arm_q     <= ready_arm_d;
            cmd_arm_q       <= cmd_arm_d;
        end
    end

    // ----------------------------------------------------------------
    // Sticky status register
    // ----------------------------------------------------------------
    assign clr_vec = wr_status ? apb_pwdata_in[SRC_N-1:0] : '0;

    // Set wins over a clear in the same cycle, so no event is lost
    always_comb begin
        status_d = (status_q & ~clr_vec) | set_vec;
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            status_q <= SRC_RST;
        end else begin
            status_q <= status_d;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt output
    // ----------------------------------------------------------------
    // Level output, follows status within the same cycle
    assign irq_out = gate_q && (|(status_q & en_q));

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    chk_global_gate: assert property (
        !gate_q |-> !irq_out
    ) else $error("interrupt raised while global gate is off");

    chk_enable_rsvd: assert property (
        (setup_cyc && addr_is(apb_paddr_in, OFS_ENABLE)) |=> (prdata_q[30:4] == 27'h0)
    ) else $error("enable register reserved bits read nonzero");

    chk_status_rsvd: assert property (
        (setup_cyc && addr_is(apb_paddr_in, OFS_STATUS)) |=> (prdata_q[31:4] == 28'h0)
    ) else $error("status register reserved bits read nonzero");

    chk_enable_write: assert property (
        wr_enable |=> (en_q == $past(apb_pwdata_in[3:0])) && (gate_q == $past(apb_pwdata_in[31]))
    ) else $error("enable write not stored");

    chk_owner_set: assert property (
        (owner_changed && owner_present_q) |=> status_q[3]
    ) else $error("owner change did not set status bit 3");

    chk_owner_quiet: assert property (
        (owner_changed && !owner_present_q && !status_q[3]) |=> !status_q[3]
    ) else $error("grant from empty owner slot set status bit 3");

    chk_flag_set: assert property (
        (flag_arm_q && !established_flag_in) |=> status_q[2]
    ) else $error("completed flag clear did not set status bit 2");

    chk_ready_set: assert property (
        (ready_request_in ##1 (ready_arm_q && !idle_flag_in)) |=> status_q[1]
    ) else $error("ready entry did not set status bit 1");

    chk_cmd_set: assert property (
        ((cmd_launch_ctrl_in == START_LAUNCH) ##1 ((cmd_launch_ctrl_in == START_CLEAR) && resp_avail_in))
        |=> status_q[0]
    ) else $error("finished command did not set status bit 0");

    chk_cancel_set: assert property (
        cmd_cancel_done_in |=> status_q[0]
    ) else $error("cancel did not set status bit 0");

    chk_zero_holds: assert property (
        (wr_status && !apb_pwdata_in[0] && status_q[0]) |=> status_q[0]
    ) else $error("writing zero cleared a status bit");

    chk_one_clears: assert property (
        (wr_status && apb_pwdata_in[2] && !set_vec[2]) |=> !status_q[2]
    ) else $error("writing one did not clear a status bit");

    chk_irq_cause: assert property (
        $rose(irq_out) |-> (gate_q && $past(gate_q && |(en_q & status_q)) || $rose(gate_q) || $changed(en_q)
                            || $changed(status_q))
    ) else $error("interrupt rose without an enabled pending source");

    cov_owner_irq: cover property (
        gate_q && en_q[3] && owner_changed && owner_present_q ##1 irq_out
    );

    cov_cmd_cancel: cover property (
        cmd_arm_q && cmd_cancel_done_in ##1 status_q[0]
    );

    cov_ack_drop: cover property (
        irq_out ##1 wr_status ##1 !irq_out
    );

endmodule : cbi_irq_ctrl

// >>> tb/cbi_irq_ctrl_tb_top.sv
// Self-checking testbench of the buffer interrupt controller, one task per scenario.
// Assumes cbi_pkg and cbi_irq_ctrl are compiled first; the APB task polls pready, so no wait count is assumed.
module cbi_irq_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cbi_pkg::*;

    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    localparam int LIMIT = 5000;
    logic                mclk_in    = 1'b0;
    logic                sys_rst_in = 1'b1;
    logic                psel       = 1'b0;
    logic                penable    = 1'b0;
    logic                pwrite     = 1'b0;
    logic [ADDR_W-1:0]   paddr      = '0;
    logic [DATA_W-1:0]   pwdata     = '0;
    logic [DATA_W-1:0]   prdata;
    logic                pready;
    logic                pslverr;
    logic [OWNER_W-1:0]  owner      = '0;
    logic                present    = 1'b0;
    logic                clr_req    = 1'b0;
    logic                est        = 1'b1;
    logic                rdy_req    = 1'b0;
    logic                idle       = 1'b1;
    logic [START_W-1:0]  launch     = START_CLEAR;
    logic                resp       = 1'b0;
    logic                cancel     = 1'b0;
    logic                irq;
    int                  fail_count = 0;
    int                  checked    = 0;
    int                  cycles     = 0;

    cbi_irq_ctrl dut (
        .mclk_in                       (mclk_in),
        .sys_rst_in                    (sys_rst_in),
        .apb_psel_in                   (psel),
        .apb_penable_in                (penable),
        .apb_pwrite_in                 (pwrite),
        .apb_paddr_in                  (paddr),
        .apb_pwdata_in                 (pwdata),
        .apb_prdata_out                (prdata),
        .apb_pready_out                (pready),
        .apb_pslverr_out               (pslverr),
        .owner_field_in                (owner),
        .owner_present_in              (present),
        .established_flag_clear_req_in (clr_req),
        .established_flag_in           (est),
        .ready_request_in              (rdy_req),
        .idle_flag_in                  (idle),
        .cmd_launch_ctrl_in            (launch),
        .resp_avail_in                 (resp),
        .cmd_cancel_done_in            (cancel),
        .irq_out                       (irq)
    );

    // Free-running 40 MHz clock
    initial begin
        forever #12.5 mclk_in = ~mclk_in;
    end

    // ----------------------------------------------------------------
    // Compare tasks and verdict
    // ----------------------------------------------------------------
    task automatic check_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp, input string msg);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %b expected %b", $time, msg, got, exp);
        end
    endtask : check_bit

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    // Hang guard: a stuck handshake still reaches the verdict
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fail_count++;
            $display("unexpected at %0t: run exceeded cycle limit", $time);
            conclude();
        end
    end

    // ----------------------------------------------------------------
    // APB master: setup, access held until pready, then release
    // ----------------------------------------------------------------
    task automatic apb_xfer(input logic wr, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] wdata,
                            output logic [DATA_W-1:0] rdata, output logic err);
        @(posedge mclk_in);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge mclk_in);
        penable <= 1'b1;
        // No assumed wait count: only the cycle limit ends a stuck access
        do begin
            @(posedge mclk_in);
        end while (pready !== 1'b1);
        rdata   = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    task automatic wr(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
        logic [DATA_W-1:0] r;
        logic              e;
        apb_xfer(1'b1, addr, data, r, e);
        check_bit(e, 1'b0, "write error flag");
    endtask : wr

    task automatic rd_chk(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] exp, input string msg);
        logic [DATA_W-1:0] r;
        logic              e;
        apb_xfer(1'b0, addr, '0, r, e);
        check_bit(e, 1'b0, "read error flag");
        check_word(r, exp, msg);
    endtask : rd_chk

    // Sample the interrupt half a cycle after the edge, when it has settled
    task automatic irq_chk(input logic exp);
        @(negedge mclk_in);
        check_bit(irq, exp, "interrupt level");
    endtask : irq_chk

    // Shared follow-up for one pending source: pending read, masking, enabling, write-zero and write-one
    task automatic check_source(input int idx);
        logic [DATA_W-1:0] b;
        b = 32'h0000_0001 << idx;
        rd_chk(OFS_STATUS, b, "pending bit");
        wr(OFS_ENABLE, 32'h8000_000f & ~b);
        irq_chk(1'b0);
        wr(OFS_ENABLE, 32'h8000_0000 | b);
        irq_chk(1'b1);
        wr(OFS_STATUS, ~b);
        rd_chk(OFS_STATUS, b, "after write zero");
        wr(OFS_STATUS, b);
        irq_chk(1'b0);
        rd_chk(OFS_STATUS, RD_ZERO, "after write one");
    endtask : check_source

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_and_reserved;
        logic [DATA_W-1:0] r;
        logic              e;
        rd_chk(OFS_ENABLE, RD_ZERO, "enable reset");
        rd_chk(OFS_STATUS, RD_ZERO, "status reset");
        irq_chk(1'b0);
        wr(OFS_ENABLE, 32'hffff_ffff);
        rd_chk(OFS_ENABLE, 32'h8000_000f, "enable reserved bits");
        wr(OFS_STATUS, 32'hffff_ffff);
        rd_chk(OFS_STATUS, RD_ZERO, "status reserved bits");
        // Unmapped word: flagged, reads zero, leaves the enables alone
        apb_xfer(1'b1, 12'h008, 32'h0000_0000, r, e);
        check_bit(e, 1'b1, "unmapped write flag");
        apb_xfer(1'b0, 12'h008, '0, r, e);
        check_bit(e, 1'b1, "unmapped read flag");
        check_word(r, RD_ZERO, "unmapped read data");
        rd_chk(OFS_ENABLE, 32'h8000_000f, "enable after unmapped");
        wr(OFS_ENABLE, RD_ZERO);
    endtask : t_reset_and_reserved

    task automatic t_cmd_done;
        // A response with no launch seen first must flag nothing
        @(posedge mclk_in);
        resp   <= 1'b1;
        @(posedge mclk_in);
        resp   <= 1'b0;
        rd_chk(OFS_STATUS, RD_ZERO, "response without launch");
        @(posedge mclk_in);
        launch <= START_LAUNCH;
        @(posedge mclk_in);
        launch <= START_CLEAR;
        resp   <= 1'b1;
        @(posedge mclk_in);
        resp   <= 1'b0;
        wr(OFS_ENABLE, 32'h0000_000f);
        irq_chk(1'b0);
        check_source(SRC_CMD);
    endtask : t_cmd_done

    task automatic t_cancel;
        // Cancel a command that is still executing: launched, no response yet
        @(posedge mclk_in);
        launch <= START_LAUNCH;
        @(posedge mclk_in);
        launch <= START_CLEAR;
        cancel <= 1'b1;
        @(posedge mclk_in);
        cancel <= 1'b0;
        check_source(SRC_CMD);
    endtask : t_cancel

    task automatic t_owner;
        // Grant from no owner: field and presence change together, nothing flagged
        @(posedge mclk_in);
        present <= 1'b1;
        owner   <= 3'h1;
        rd_chk(OFS_STATUS, RD_ZERO, "grant from empty");
        @(posedge mclk_in);
        owner <= 3'h2;
        check_source(SRC_OWNER);
    endtask : t_owner

    task automatic t_flag_clear;
        @(posedge mclk_in);
        clr_req <= 1'b1;
        @(posedge mclk_in);
        clr_req <= 1'b0;
        est     <= 1'b0;
        check_source(SRC_FLAG);
    endtask : t_flag_clear

    task automatic t_ready;
        @(posedge mclk_in);
        rdy_req <= 1'b1;
        @(posedge mclk_in);
        rdy_req <= 1'b0;
        idle    <= 1'b0;
        check_source(SRC_READY);
    endtask : t_ready

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        t_reset_and_reserved();
        t_cmd_done();
        t_cancel();
        t_owner();
        t_flag_clear();
        t_ready();
        conclude();
    end

endmodule : cbi_irq_ctrl_tb_top
